// >>> hw/sdg_pkg.sv
package sdg_pkg;
  // register byte addresses (printed offsets are indices, not all multiples of four)
  localparam logic [7:0] REG_GENERAL_CONFIG_IDX = 8'h00;
  localparam logic [7:0] REG_GEARING_FACTOR_IDX = 8'h12;
  localparam logic [7:0] REG_ACTUAL_POSITION_IDX = 8'h21;
  localparam logic [7:0] REG_STATUS_IDX = 8'h0f;
  localparam logic [9:0] ADDR_GENERAL_CONFIG = {REG_GENERAL_CONFIG_IDX, 2'b00};
  localparam logic [9:0] ADDR_GEARING_FACTOR = {REG_GEARING_FACTOR_IDX, 2'b00};
  localparam logic [9:0] ADDR_ACTUAL_POSITION = {REG_ACTUAL_POSITION_IDX, 2'b00};
  localparam logic [9:0] ADDR_STATUS = {REG_STATUS_IDX, 2'b00};
  // general_config fields
  localparam int STEP_SEL_LSB = 6;
  localparam int DIR_INV_BIT = 8;
  localparam logic [31:0] GENERAL_CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] GENERAL_CONFIG_MASK = 32'h0400_03c0;
  localparam logic [31:0] GEARING_FACTOR_RESET = 32'h0100_0000;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;
  localparam int FRAC_BITS = 24;
  localparam int GEAR_BITS = 32;
  // step output pulse timing, in ns and cycles at 10 MHz
  localparam int CLK_PERIOD_NS = 100;
  localparam int STEP_HIGH_NS = 200;
  localparam int STEP_HIGH_CYC = (STEP_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] STEP_HIGH_CNT = 8'(STEP_HIGH_CYC);
  localparam logic [7:0] STEP_LOW_CNT = 8'(STEP_HIGH_CYC);
  localparam logic [1:0] SEL_INTERNAL = 2'h0;
  localparam logic [1:0] SEL_RISING = 2'h1;
  localparam logic [1:0] SEL_FALLING = 2'h2;
  localparam logic [1:0] SEL_TOGGLE = 2'h3;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } sdg_bus_state_t;

  typedef enum logic [1:0] {
    PULSE_IDLE = 2'b00,
    PULSE_HIGH = 2'b01,
    PULSE_LOW  = 2'b11
  } sdg_pulse_state_t;

  typedef struct packed {
    logic [9:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } sdg_avs_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } sdg_avs_rsp_t;
endpackage

// >>> hw/sdg_pin_sync.sv
`timescale 1ns/1ps
module sdg_pin_sync
  import sdg_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pin in, filtered level out
  input  wire logic pinIn,
  output logic      level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sdg_sync_state_t;

  sdg_sync_state_t st;
  sdg_sync_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.s1 = pinIn;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    // change counts only once second and third stages agree
    if (st.s2 == st.s3) begin
      next_st.lvl = st.s3;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.lvl;
endmodule

// >>> hw/sdg_step_dir_input_gearing.sv
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
// Function
// - nonzero step select disables internal stepping, uses external step input
// - select 01 counts each rising edge of the step input
// - select 10 counts each falling edge of the step input
// - select 11 counts every step input transition
// - invert bit clear: low direction input means negative direction
// - invert bit set: high direction input means negative direction
// - gearing factor is signed 32 bits, 8 integer, 24 fraction
// - each counted external step adds gearing factor to accumulator
// - accumulator overflow makes one internal step, remainder kept
// - negative gearing factor inverts interpretation of input direction
// - magnitude above one may give a burst of output steps
module sdg_step_dir_input_gearing
  import sdg_pkg::*;
(
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // avalon-mm slave
  input  wire sdg_avs_req_t avsReq,
  output sdg_avs_rsp_t      avsRsp,
  // external step and direction pins
  input  wire logic         extStepIn,
  input  wire logic         extDirIn,
  // internal step generator request, used only when external select is zero
  input  wire logic         intStepReq,
  input  wire logic         intDirReq,
  // motor pins and internal generator enable
  output logic              stepOutPin,
  output logic              dirOutPin,
  output logic              intGenEnable
);
  typedef struct packed {
    sdg_bus_state_t   bus;
    logic [31:0]      readData;
    logic             waitReq;
    logic [31:0]      generalConfig;
    logic [31:0]      gearingFactor;
    logic [31:0]      accum;
    logic [31:0]      actualPosition;
    logic             stepPrev;
    logic [7:0]       pendPos;
    logic [7:0]       pendNeg;
    logic             overrun;
    sdg_pulse_state_t pulse;
    logic [7:0]       pulseCnt;
    logic             pulseDir;
    logic             stepOut;
    logic             dirOut;
    logic             genEnable;
  } sdg_state_t;

  sdg_state_t st;
  sdg_state_t next_st;
  logic       stepLvl;
  logic       dirLvl;

  sdg_pin_sync u_step_sync (
    .clk   (clk),
    .rst   (rst),
    .pinIn (extStepIn),
    .level (stepLvl)
  );

  sdg_pin_sync u_dir_sync (
    .clk   (clk),
    .rst   (rst),
    .pinIn (extDirIn),
    .level (dirLvl)
  );

  logic [1:0]  stepSel;
  logic        dirInv;
  logic        extMode;
  logic        extStep;
  logic        inPositive;
  logic        gearNeg;
  logic [31:0] magnitude;

  always_comb begin
    stepSel = st.generalConfig[STEP_SEL_LSB +: 2];
    dirInv = st.generalConfig[DIR_INV_BIT];
    extMode = (stepSel != SEL_INTERNAL);
    gearNeg = st.gearingFactor[GEAR_BITS-1];
    extStep = 1'b0;
    case (stepSel)
      SEL_RISING: begin
        extStep = stepLvl & ~st.stepPrev;
      end
      SEL_FALLING: begin
        extStep = ~stepLvl & st.stepPrev;
      end
      SEL_TOGGLE: begin
        extStep = stepLvl ^ st.stepPrev;
      end
      default: begin
        extStep = 1'b0;
      end
    endcase
    // polarity, negative when level equals invert bit
    inPositive = (dirLvl != dirInv);
    // sign of factor flips input direction
    if (gearNeg) begin
      inPositive = ~inPositive;
    end
    magnitude = gearNeg ? (~st.gearingFactor + 32'h0000_0001) : st.gearingFactor;
  end

  // integer part of an overflow is the number of whole internal steps
  logic [7:0] stepsNow;
  logic [31:0] accNext;
  always_comb begin
    stepsNow = 8'h00;
    accNext = st.accum;
    if (inPositive) begin
      accNext = {8'h00, st.accum[FRAC_BITS-1:0]} + {8'h00, magnitude[FRAC_BITS-1:0]};
      stepsNow = magnitude[GEAR_BITS-1:FRAC_BITS] + {7'h00, accNext[FRAC_BITS]};
    end else begin
      accNext = {8'h00, st.accum[FRAC_BITS-1:0]} - {8'h00, magnitude[FRAC_BITS-1:0]};
      stepsNow = magnitude[GEAR_BITS-1:FRAC_BITS] + {7'h00, accNext[GEAR_BITS-1]};
    end
    accNext = {8'h00, accNext[FRAC_BITS-1:0]};
  end

  always_comb begin
    next_st = st;
    next_st.stepPrev = stepLvl;
    // external select turns off internal generator
    next_st.genEnable = ~extMode;

    // bus slave, one wait cycle then answer
    next_st.waitReq = 1'b1;
    case (st.bus)
      BUS_IDLE: begin
        if (avsReq.read | avsReq.write) begin
          next_st.bus = BUS_ACK;
          next_st.waitReq = 1'b0;
          case (avsReq.address)
            ADDR_GENERAL_CONFIG: next_st.readData = st.generalConfig;
            ADDR_GEARING_FACTOR: next_st.readData = st.gearingFactor;
            ADDR_ACTUAL_POSITION: next_st.readData = st.actualPosition;
            ADDR_STATUS: next_st.readData = {29'h0, st.overrun, st.pulse != PULSE_IDLE,
                                             extMode};
            default: next_st.readData = READ_UNMAPPED;
          endcase
        end
      end
      BUS_ACK: begin
        next_st.bus = BUS_IDLE;
        // write lands at the edge where waitrequest is seen low
        if (avsReq.write) begin
          for (int b = 0; b < 4; b++) begin
            if (avsReq.byteenable[b]) begin
              if (avsReq.address == ADDR_GENERAL_CONFIG) begin
                next_st.generalConfig[8*b +: 8] = avsReq.writedata[8*b +: 8]
                                                 & GENERAL_CONFIG_MASK[8*b +: 8];
              end
              if (avsReq.address == ADDR_GEARING_FACTOR) begin
                next_st.gearingFactor[8*b +: 8] = avsReq.writedata[8*b +: 8];
              end
            end
          end
        end
      end
      default: begin
        next_st.bus = BUS_IDLE;
      end
    endcase

    // add factor on each external step, keep fractional remainder
    if (extMode && extStep) begin
      next_st.accum = accNext;
      if (inPositive) begin
        if ({1'b0, st.pendPos} + {1'b0, stepsNow} > 9'h0ff) begin
          next_st.overrun = 1'b1;
          next_st.pendPos = 8'hff;
        end else begin
          next_st.pendPos = st.pendPos + stepsNow;
        end
      end else begin
        if ({1'b0, st.pendNeg} + {1'b0, stepsNow} > 9'h0ff) begin
          next_st.overrun = 1'b1;
          next_st.pendNeg = 8'hff;
        end else begin
          next_st.pendNeg = st.pendNeg + stepsNow;
        end
      end
    end

    // pending steps leave as a paced burst
    case (st.pulse)
      PULSE_IDLE: begin
        next_st.stepOut = 1'b0;
        if (extMode && (st.pendPos != 8'h00 || st.pendNeg != 8'h00)) begin
          next_st.pulseDir = (st.pendPos != 8'h00);
          next_st.dirOut = (st.pendPos != 8'h00);
          next_st.pulse = PULSE_HIGH;
          next_st.pulseCnt = STEP_HIGH_CNT;
          next_st.stepOut = 1'b1;
          if (st.pendPos != 8'h00) begin
            next_st.pendPos = next_st.pendPos - 8'h01;
            next_st.actualPosition = st.actualPosition + 32'h0000_0001;
          end else begin
            next_st.pendNeg = next_st.pendNeg - 8'h01;
            next_st.actualPosition = st.actualPosition - 32'h0000_0001;
          end
        end else if (!extMode && intStepReq) begin
          next_st.dirOut = intDirReq;
          next_st.pulse = PULSE_HIGH;
          next_st.pulseCnt = STEP_HIGH_CNT;
          next_st.stepOut = 1'b1;
          next_st.actualPosition = intDirReq ? st.actualPosition + 32'h0000_0001
                                             : st.actualPosition - 32'h0000_0001;
        end
      end
      PULSE_HIGH: begin
        next_st.pulseCnt = st.pulseCnt - 8'h01;
        if (st.pulseCnt == 8'h01) begin
          next_st.stepOut = 1'b0;
          next_st.pulse = PULSE_LOW;
          next_st.pulseCnt = STEP_LOW_CNT;
        end
      end
      PULSE_LOW: begin
        next_st.pulseCnt = st.pulseCnt - 8'h01;
        if (st.pulseCnt == 8'h01) begin
          next_st.pulse = PULSE_IDLE;
        end
      end
      default: begin
        next_st.pulse = PULSE_IDLE;
        next_st.stepOut = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.bus <= BUS_IDLE;
      st.waitReq <= 1'b1;
      st.generalConfig <= GENERAL_CONFIG_RESET;
      st.gearingFactor <= GEARING_FACTOR_RESET;
      st.pulse <= PULSE_IDLE;
      st.genEnable <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign avsRsp.readdata = st.readData;
  assign avsRsp.waitrequest = st.waitReq;
  assign stepOutPin = st.stepOut;
  assign dirOutPin = st.dirOut;
  assign intGenEnable = st.genEnable;
endmodule

// >>> bench/sdg_gearing_sva.sv
`timescale 1ns/1ps
module sdg_gearing_sva
  import sdg_pkg::*;
(
  // clock and reset
  input wire logic         clk,
  input wire logic         rst,
  // register bus
  input wire sdg_avs_req_t avsReq,
  input wire sdg_avs_rsp_t avsRsp,
  // pins
  input wire logic         extStepIn,
  input wire logic         extDirIn,
  input wire logic         intStepReq,
  input wire logic         intDirReq,
  input wire logic         stepOutPin,
  input wire logic         dirOutPin,
  input wire logic         intGenEnable
);
  logic [31:0] cfg;
  logic [31:0] gear;
  logic [31:0] bm;
  logic        wrDone;
  logic        rdDone;
  logic        mapped;
  assign bm     = {{8{avsReq.byteenable[3]}}, {8{avsReq.byteenable[2]}},
                   {8{avsReq.byteenable[1]}}, {8{avsReq.byteenable[0]}}};
  assign wrDone = avsReq.write && !avsRsp.waitrequest;
  assign rdDone = avsReq.read && !avsRsp.waitrequest;
  assign mapped = avsReq.address inside {ADDR_GENERAL_CONFIG, ADDR_GEARING_FACTOR,
                                         ADDR_ACTUAL_POSITION, ADDR_STATUS};
  // shadow copies of what software wrote
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg  <= GENERAL_CONFIG_RESET;
      gear <= GEARING_FACTOR_RESET;
    end else if (wrDone && avsReq.address == ADDR_GENERAL_CONFIG) begin
      cfg <= ((cfg & ~bm) | (avsReq.writedata & bm)) & GENERAL_CONFIG_MASK;
    end else if (wrDone && avsReq.address == ADDR_GEARING_FACTOR) begin
      gear <= (gear & ~bm) | (avsReq.writedata & bm);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_pulse;
    stepOutPin[*2] ##1 !stepOutPin;
  endsequence
  a_bus_answer: assert property ($rose(avsReq.read || avsReq.write) |=> !avsRsp.waitrequest)
    else $error("bus answer late");
  a_bus_idle: assert property (!(avsReq.read || avsReq.write) |-> avsRsp.waitrequest)
    else $error("waitrequest low while idle");
  a_bus_unmapped: assert property (rdDone && !mapped |-> avsRsp.readdata == READ_UNMAPPED)
    else $error("unmapped read not zero");
  a_cfg_readback: assert property (
    rdDone && avsReq.address == ADDR_GENERAL_CONFIG |-> avsRsp.readdata == cfg)
    else $error("config readback wrong");
  a_gear_readback: assert property (
    rdDone && avsReq.address == ADDR_GEARING_FACTOR |-> avsRsp.readdata == gear)
    else $error("gearing readback wrong");
  a_gen_enable: assert property (
    wrDone && avsReq.address == ADDR_GENERAL_CONFIG |-> ##2 intGenEnable == (cfg[7:6] == SEL_INTERNAL))
    else $error("internal generator enable wrong");
  a_pulse_shape: assert property ($rose(stepOutPin) |-> s_pulse)
    else $error("step pulse not two cycles");
  a_pulse_gap: assert property ($fell(stepOutPin) |=> !stepOutPin)
    else $error("step low time too short");
  a_dir_steady: assert property (stepOutPin && $past(stepOutPin) |-> $stable(dirOutPin))
    else $error("direction moved during step");
  a_rise_step: assert property (
    cfg[7:6] == SEL_RISING && gear == GEARING_FACTOR_RESET && $rose(extStepIn)
      |-> ##[2:8] $rose(stepOutPin))
    else $error("rising input gave no step");
endmodule

bind sdg_step_dir_input_gearing sdg_gearing_sva u_sva (.clk(clk), .rst(rst), .avsReq(avsReq),
  .avsRsp(avsRsp), .extStepIn(extStepIn), .extDirIn(extDirIn), .intStepReq(intStepReq),
  .intDirReq(intDirReq), .stepOutPin(stepOutPin), .dirOutPin(dirOutPin),
  .intGenEnable(intGenEnable));

// >>> bench/sdg_sd_source.sv
`timescale 1ns/1ps
module sdg_sd_source (
  // clock
  input  wire logic       clk,
  // command
  input  wire logic       go,
  input  wire logic [7:0] count,
  input  wire logic       dirLvl,
  // pins toward the device, and busy back to the bench
  output logic            extStepIn,
  output logic            extDirIn,
  output logic            busy
);
  logic [7:0] left = 8'h00;
  logic [7:0] tick = 8'h00;
  initial extStepIn = 1'b0;
  initial extDirIn = 1'b0;
  initial busy = 1'b0;
  // direction settles first; edges far apart so the synchroniser sees each one
  always @(posedge clk) begin
    if (go && !busy) begin
      extDirIn <= dirLvl;
      left <= count;
      tick <= 8'h08;
      busy <= 1'b1;
    end else if (busy) begin
      if (tick != 8'h00) begin
        tick <= tick - 8'h01;
      end else if (left == 8'h00) begin
        busy <= 1'b0;
      end else begin
        extStepIn <= ~extStepIn;
        left <= left - 8'h01;
        tick <= 8'h08;
      end
    end
  end
endmodule

// >>> bench/sdg_step_dir_input_gearing_bench.sv
`timescale 1ns/1ps
module sdg_step_dir_input_gearing_bench
  import sdg_pkg::*;
;
  logic clk = 0, rst = 1, go = 0, dirLvl = 0, intStepReq = 0, intDirReq = 0, prevStep = 0;
  logic [7:0] count = 0;
  logic [31:0] rd;
  logic signed [31:0] expPos = 0;
  sdg_avs_req_t avsReq = '0;
  sdg_avs_rsp_t avsRsp;
  logic extStepIn, extDirIn, busy, stepOutPin, dirOutPin, intGenEnable;
  int fails = 0, n_checks = 0, steps = 0, quiet = 0;
  always #50 clk = ~clk;
  always @(posedge clk) begin
    prevStep <= stepOutPin;
    if (stepOutPin && !prevStep) steps <= steps + 1;
    quiet <= stepOutPin ? 0 : quiet + 1;
  end
  sdg_step_dir_input_gearing DUT (.clk(clk), .rst(rst), .avsReq(avsReq), .avsRsp(avsRsp),
    .extStepIn(extStepIn), .extDirIn(extDirIn), .intStepReq(intStepReq),
    .intDirReq(intDirReq), .stepOutPin(stepOutPin), .dirOutPin(dirOutPin),
    .intGenEnable(intGenEnable));
  sdg_sd_source u_src (.clk(clk), .go(go), .count(count), .dirLvl(dirLvl),
    .extStepIn(extStepIn), .extDirIn(extDirIn), .busy(busy));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    avsReq <= '{address: a, read: !w, write: w, writedata: d, byteenable: 4'hf};
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (avsRsp.waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      fails++;
      finish_test();
    end
    rd = avsRsp.readdata;
    avsReq.read <= 1'b0;
    avsReq.write <= 1'b0;
  endtask
  task automatic rdchk(input string n, input logic [9:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(n, exp, rd);
  endtask
  // n input edges, optional internal request, expected steps and direction
  task automatic run(input logic [7:0] n, input logic d, input logic p, input int e,
                     input logic ed);
    int i, base;
    base = steps;
    @(posedge clk);
    count <= n;
    dirLvl <= d;
    go <= 1'b1;
    intStepReq <= p;
    intDirReq <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    intStepReq <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 2000 && (busy || quiet < 40); i++) @(posedge clk);
    if (i == 2000) begin
      fails++;
      finish_test();
    end
    chk("steps", 32'(e), 32'(steps - base));
    chk("dir", {31'h0, ed}, {31'h0, dirOutPin});
    expPos = expPos + (ed ? e : -e);
    rdchk("position", ADDR_ACTUAL_POSITION, expPos);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    rdchk("config", ADDR_GENERAL_CONFIG, GENERAL_CONFIG_RESET);
    rdchk("gear", ADDR_GEARING_FACTOR, GEARING_FACTOR_RESET);
    rdchk("unmapped", 10'h3fc, READ_UNMAPPED);
    chk("gen", 32'h1, {31'h0, intGenEnable});
    bus(1'b1, ADDR_GENERAL_CONFIG, 32'hffff_ffff);
    rdchk("config", ADDR_GENERAL_CONFIG, GENERAL_CONFIG_MASK);
    bus(1'b1, ADDR_GEARING_FACTOR, 32'h7f00_0000);
    rdchk("gear", ADDR_GEARING_FACTOR, 32'h7f00_0000);
    bus(1'b1, ADDR_GEARING_FACTOR, 32'h0100_0000);
    for (int m = 1; m < 4; m++) begin
      bus(1'b1, ADDR_GENERAL_CONFIG, 32'(m) << STEP_SEL_LSB);
      run(8'd4, 1'b1, 1'b1, (m == 3) ? 4 : 2, 1'b1);
      chk("gen", 32'h0, {31'h0, intGenEnable});
    end
    bus(1'b1, ADDR_GENERAL_CONFIG, {SEL_RISING, 6'h0} | (32'h1 << DIR_INV_BIT));
    run(8'd4, 1'b1, 1'b0, 2, 1'b0);
    bus(1'b1, ADDR_GENERAL_CONFIG, {SEL_RISING, 6'h0});
    run(8'd4, 1'b0, 1'b0, 2, 1'b0);
    bus(1'b1, ADDR_GEARING_FACTOR, 32'hff00_0000);
    run(8'd4, 1'b1, 1'b0, 2, 1'b0);
    bus(1'b1, ADDR_GEARING_FACTOR, 32'h0080_0000);
    bus(1'b1, ADDR_GENERAL_CONFIG, {SEL_TOGGLE, 6'h0});
    run(8'd4, 1'b1, 1'b0, 2, 1'b1);
    bus(1'b1, ADDR_GEARING_FACTOR, 32'h0280_0000);
    bus(1'b1, ADDR_GENERAL_CONFIG, {SEL_RISING, 6'h0});
    run(8'd4, 1'b1, 1'b0, 5, 1'b1);
    rdchk("status", ADDR_STATUS, 32'h1);
    bus(1'b1, ADDR_GENERAL_CONFIG, 32'h0);
    run(8'd4, 1'b0, 1'b1, 1, 1'b1);
    chk("gen", 32'h1, {31'h0, intGenEnable});
    rdchk("status", ADDR_STATUS, 32'h0);
    finish_test();
  end
endmodule
